//--- dtc_pins_model.sv
// Model of the external clock and direction pins.
// Assumes the block synchronises them; edges are kept well apart.
`default_nettype none

module dtc_pins_model (
    input  wire logic clk_i,
    output logic      t1_clk_o,
    output logic      t1_dir_o,
    output logic      t2_clk_o,
    output logic      t2_dir_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {t1_clk_o, t1_dir_o, t2_clk_o, t2_dir_o} = 4'h0;
    end
    // ====================
    // One quadrature edge on the clock pin, then a pause
    task automatic quad1(input int gap);
        @(posedge clk_i);
        t1_clk_o <= ~t1_clk_o;
        repeat (gap) @(posedge clk_i);
    endtask
    // Pulses on the second clock pin; gap sets how slow
    task automatic ext2(input int n, input int gap);
        repeat (n) begin
            @(posedge clk_i);
            t2_clk_o <= 1'b1;
            repeat (gap) @(posedge clk_i);
            t2_clk_o <= 1'b0;
            repeat (gap) @(posedge clk_i);
        end
    endtask
    task automatic dir2(input logic v);
        @(posedge clk_i);
        t2_dir_o <= v;
    endtask
endmodule

`default_nettype wire

//--- dtc_pkg.sv
// Package for the dual up/down timer/counter block.
// Assumes a single 25 MHz core clock and a classic Wishbone master.
`default_nettype none

package dtc_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [13:0] IDX_RELOAD = 14'h1F72;
    localparam logic [13:0] IDX_CTRL1  = 14'h1F78;
    localparam logic [13:0] IDX_VALUE1 = 14'h1F7A;
    localparam logic [13:0] IDX_CTRL2  = 14'h1F7C;
    localparam logic [13:0] IDX_VALUE2 = 14'h1F7E;
    localparam logic [13:0] IDX_MASK   = 14'h1FBC;
    localparam logic [13:0] IDX_PEND   = 14'h1FBE;

    // ==========================================================
    // Counter constants
    localparam logic [15:0] CNT_NEAR_MAX = 16'hFFFE;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    // Core clocks per count at prescale 0
    localparam logic [7:0]  BASE_DIV     = 8'h02;
    localparam logic [7:0]  PRE_ONE      = 8'h01;

    // ==========================================================
    // Count clock source
    typedef enum logic [1:0] {
        SRC_INT,
        SRC_EXT,
        SRC_ALT,
        SRC_ALT_RELOAD
    } dtc_src_t;

    // Control register layout, eight bits
    typedef struct packed {
        logic     run;
        logic     up;
        dtc_src_t src;
        logic     dir_ext;
        logic [2:0] psc;
    } dtc_ctrl_t;

    // Pending and mask layout
    typedef struct packed {
        logic [5:0] rsvd;
        logic       t2;
        logic       t1;
    } dtc_irq_t;

    // Two-stage synchroniser plus edge history
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } dtc_sync_t;

    // One counter with its prescaler and pin samplers
    typedef struct packed {
        logic [15:0] cnt;
        logic [7:0]  pre;
        dtc_sync_t   sclk;
        dtc_sync_t   sdir;
    } dtc_tmr_t;

    // Whole state of the block
    typedef struct packed {
        dtc_tmr_t    t1;
        dtc_tmr_t    t2;
        dtc_ctrl_t   c1;
        dtc_ctrl_t   c2;
        logic [15:0] reload;
        dtc_irq_t    mask;
        dtc_irq_t    pend;
        logic        ack;
        logic [31:0] dat;
    } dtc_state_t;

endpackage

`default_nettype wire

//--- dtc_timer.sv
// Dual 16-bit up/down timer/counter with Wishbone register slave.
// Assumes external clock and direction pins are asynchronous; they
// are synchronised here. One clock domain, synchronous reset.
//
// Functional notes
// - Two 16-bit up/down counters, internal/external clock
// - Flag on FFFE->FFFF up or 0001->0000 down
// - Interrupt only when pending bit is enabled
// - At most one count per two core clocks, except in quadrature
// - Prescaler divisor from each control register
// - Control sets run, direction, sources, prescale
// - Quadrature plus reload copies reload on overflow
// - Reload register holds value until rewritten
// - Cascade clocks counter two from counter one
// - Cascade direction from own bit or counter one
// - Mask enables each counter interrupt individually
// - Pending register shows waiting requests
// - Value registers read back present count
`default_nettype none

module dtc_timer
    import dtc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        t1_clk_i,
    input  wire logic        t1_dir_i,
    input  wire logic        t2_clk_i,
    input  wire logic        t2_dir_i,
    output logic             t1_ovf_o,
    output logic             t2_ovf_o,
    output logic             irq_o
);

    // ==========================================================
    // Helpers

    // Returns {overflow, next count}; wraps modulo 65536
    function automatic logic [16:0] step(
        input logic [15:0] c,
        input logic        up
    );
        logic        ovf;
        logic [15:0] n;
        ovf = 1'b0;
        n   = c;
        if (up) begin
            ovf = (c == CNT_NEAR_MAX);
            n   = c + CNT_ONE;
        end else begin
            ovf = (c == CNT_ONE);
            n   = c - CNT_ONE;
        end
        return {ovf, n};
    endfunction

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  s
    );
        logic [15:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // Prescaler limit: BASE_DIV core clocks times 2**psc, minus one
    function automatic logic [7:0] pre_lim(input logic [2:0] p);
        return (BASE_DIV << p) - PRE_ONE;
    endfunction

    // Shift a pin into its synchroniser
    function automatic dtc_sync_t sync_in(
        input dtc_sync_t s,
        input logic      pin
    );
        dtc_sync_t r;
        r.s1   = pin;
        r.s2   = s.s1;
        r.prev = s.s2;
        return r;
    endfunction

    // ==========================================================
    // State

    dtc_state_t st;
    dtc_state_t next_st;

    // Decoded events, filled in the combinational process
    logic        hit;
    logic [13:0] idx;
    logic        tick1;
    logic        tick2;
    logic        up1;
    logic        up2;
    logic        ovf1;
    logic        ovf2;
    logic        quad_a_chg;
    logic        quad_b_chg;
    logic [16:0] s1r;
    logic [16:0] s2r;

    // ==========================================================
    // Next-state logic

    always_comb begin
        next_st    = st;
        hit        = cyc_i & stb_i & ~st.ack;
        idx        = adr_i[15:2];
        tick1      = 1'b0;
        tick2      = 1'b0;
        up1        = st.c1.up;
        up2        = st.c2.up;
        ovf1       = 1'b0;
        ovf2       = 1'b0;
        quad_a_chg = 1'b0;
        quad_b_chg = 1'b0;
        s1r        = '0;
        s2r        = '0;

        // Pins pass two flip-flops before any use
        next_st.t1.sclk = sync_in(st.t1.sclk, t1_clk_i);
        next_st.t1.sdir = sync_in(st.t1.sdir, t1_dir_i);
        next_st.t2.sclk = sync_in(st.t2.sclk, t2_clk_i);
        next_st.t2.sdir = sync_in(st.t2.sdir, t2_dir_i);

        // ------------------------------------------------------
        // Prescalers; a stopped counter holds its divider at zero
        if (st.c1.run && st.t1.pre != pre_lim(st.c1.psc)) begin
            next_st.t1.pre = st.t1.pre + PRE_ONE;
        end else begin
            next_st.t1.pre = '0;
        end
        if (st.c2.run && st.t2.pre != pre_lim(st.c2.psc)) begin
            next_st.t2.pre = st.t2.pre + PRE_ONE;
        end else begin
            next_st.t2.pre = '0;
        end

        // ------------------------------------------------------
        // Counter one clock and direction
        if (st.c1.dir_ext) begin
            up1 = st.t1.sdir.s2;
        end
        quad_a_chg = st.t1.sclk.s2 ^ st.t1.sclk.prev;
        quad_b_chg = st.t1.sdir.s2 ^ st.t1.sdir.prev;
        case (st.c1.src)
            SRC_INT: begin
                // Divider of at least two keeps the rate bounded
                tick1 = st.t1.pre == pre_lim(st.c1.psc);
            end
            SRC_EXT: begin
                tick1 = st.t1.sclk.s2 & ~st.t1.sclk.prev;
            end
            SRC_ALT, SRC_ALT_RELOAD: begin
                // Quadrature: count each edge of either input
                tick1 = quad_a_chg | quad_b_chg;
                up1   = ~(st.t1.sclk.prev ^ st.t1.sdir.s2);
            end
            default: begin
                tick1 = 1'b0;
            end
        endcase
        tick1 = tick1 & st.c1.run;

        s1r  = step(st.t1.cnt, up1);
        ovf1 = tick1 & s1r[16];
        if (tick1) begin
            if (ovf1 && st.c1.src == SRC_ALT_RELOAD) begin
                next_st.t1.cnt = st.reload;
            end else begin
                next_st.t1.cnt = s1r[15:0];
            end
        end

        // ------------------------------------------------------
        // Counter two clock and direction
        if (st.c2.dir_ext) begin
            up2 = st.t2.sdir.s2;
        end
        case (st.c2.src)
            SRC_INT: begin
                tick2 = st.t2.pre == pre_lim(st.c2.psc);
            end
            SRC_EXT: begin
                tick2 = st.t2.sclk.s2 & ~st.t2.sclk.prev;
            end
            SRC_ALT, SRC_ALT_RELOAD: begin
                // Cascade: counter one overflow is the clock
                tick2 = ovf1;
                up2   = st.c2.dir_ext ? up1 : st.c2.up;
            end
            default: begin
                tick2 = 1'b0;
            end
        endcase
        tick2 = tick2 & st.c2.run;

        s2r  = step(st.t2.cnt, up2);
        ovf2 = tick2 & s2r[16];
        if (tick2) begin
            next_st.t2.cnt = s2r[15:0];
        end

        // ------------------------------------------------------
        // Register slave; one wait-free cycle to ack
        next_st.ack = hit;
        if (hit && !we_i) begin
            next_st.dat = '0;
            case (idx)
                IDX_RELOAD: next_st.dat[15:0] = st.reload;
                IDX_CTRL1:  next_st.dat[7:0]  = st.c1;
                IDX_VALUE1: next_st.dat[15:0] = st.t1.cnt;
                IDX_CTRL2:  next_st.dat[7:0]  = st.c2;
                IDX_VALUE2: next_st.dat[15:0] = st.t2.cnt;
                IDX_MASK:   next_st.dat[7:0]  = st.mask;
                IDX_PEND:   next_st.dat[7:0]  = st.pend;
                default:    next_st.dat       = '0;
            endcase
            if (idx == IDX_PEND) begin
                next_st.pend = '0;                  // Read clears
            end
        end

        if (hit && we_i) begin
            case (idx)
                IDX_RELOAD: begin
                    // Only a bus write changes it
                    next_st.reload = merge16(st.reload, dat_i,
                                             sel_i);
                end
                IDX_CTRL1: begin
                    if (sel_i[0]) begin
                        next_st.c1 = dat_i[7:0];
                    end
                end
                IDX_VALUE1: begin
                    // Bus write wins over a count in the same cycle
                    next_st.t1.cnt = merge16(st.t1.cnt, dat_i, sel_i);
                end
                IDX_CTRL2: begin
                    if (sel_i[0]) begin
                        next_st.c2 = dat_i[7:0];
                    end
                end
                IDX_VALUE2: begin
                    next_st.t2.cnt = merge16(st.t2.cnt, dat_i, sel_i);
                end
                IDX_MASK: begin
                    if (sel_i[0]) begin
                        next_st.mask.t1 = dat_i[0];
                        next_st.mask.t2 = dat_i[1];
                    end
                end
                default: begin
                    // Pending and unmapped writes are ignored
                end
            endcase
        end

        // ------------------------------------------------------
        // Events set pending after the read clear, so set wins
        if (ovf1) begin
            next_st.pend.t1 = 1'b1;
        end
        if (ovf2) begin
            next_st.pend.t2 = 1'b1;
        end
        next_st.pend.rsvd = '0;
        next_st.mask.rsvd = '0;

        if (rst_i) begin
            next_st = '0;
        end
    end

    // ==========================================================
    // State register

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // ==========================================================
    // Outputs

    assign ack_o    = st.ack;
    assign dat_o    = st.dat;
    assign t1_ovf_o = ovf1;
    assign t2_ovf_o = ovf2;
    // Level output while any enabled flag waits
    assign irq_o    = |(st.pend & st.mask);

endmodule

`default_nettype wire

//--- dtc_timer_chk.sv
// Port checker for the dual up/down timer/counter.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module dtc_timer_chk
    import dtc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [31:0] dat_o,
    input  wire logic        ack_o,
    input  wire logic        t1_clk_i,
    input  wire logic        t1_dir_i,
    input  wire logic        t2_clk_i,
    input  wire logic        t2_dir_i,
    input  wire logic        t1_ovf_o,
    input  wire logic        t2_ovf_o,
    input  wire logic        irq_o
);
    // ====================
    // Bus and counter properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic rd_pend;
    assign req = cyc_i && stb_i && !ack_o;
    // A clearing read is only judged when no event lands with it
    assign rd_pend = req && !we_i && adr_i[15:2] == IDX_PEND
                     && !t1_ovf_o && !t2_ovf_o;

    a_ack_follow: assert property (req |=> ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(req))
        else $error("ack without request");
    a_read_upper: assert property (ack_o |-> !(|dat_o[31:16]))
        else $error("upper read bits not zero");
    a_dat_hold: assert property (!$past(req && !we_i) |-> $stable(dat_o))
        else $error("read data moved without read");
    a_pend_clear: assert property (rd_pend |=> !irq_o)
        else $error("irq stays after pending read");
    a_irq_cause: assert property ($rose(irq_o) |->
        $past(t1_ovf_o || t2_ovf_o || (cyc_i && stb_i && we_i)))
        else $error("irq rose without cause");
    a_ovf1_gap: assert property (t1_ovf_o |=> !t1_ovf_o)
        else $error("counter one too fast");
    a_ovf2_gap: assert property (t2_ovf_o |=> !t2_ovf_o)
        else $error("counter two too fast");

    c_ovf1: cover property (t1_ovf_o);
    c_ovf2: cover property (t2_ovf_o);
    c_irq: cover property ($rose(irq_o));
endmodule

bind dtc_timer dtc_timer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .t1_clk_i(t1_clk_i), .t1_dir_i(t1_dir_i), .t2_clk_i(t2_clk_i),
    .t2_dir_i(t2_dir_i), .t1_ovf_o(t1_ovf_o), .t2_ovf_o(t2_ovf_o),
    .irq_o(irq_o));

`default_nettype wire

//--- dual_updown_timer_counter_tb_top.sv
// Testbench top for the dual up/down timer/counter.
// Assumes the bound checker and the pin model beside the design.
`default_nettype none

`define CHK(nm, exp, got) begin checked++; \
    if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); end end

module dual_updown_timer_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dtc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack, ovf1, ovf2, irq, p1c, p1d, p2c, p2d;
    logic [15:0] d;
    int          num_errors = 0, checked = 0, cycles = 0;
    logic [13:0] regs [7] = '{IDX_RELOAD, IDX_CTRL1, IDX_VALUE1,
                              IDX_CTRL2, IDX_VALUE2, IDX_MASK, IDX_PEND};

    dtc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .t1_clk_i(p1c),
        .t1_dir_i(p1d), .t2_clk_i(p2c), .t2_dir_i(p2d),
        .t1_ovf_o(ovf1), .t2_ovf_o(ovf2), .irq_o(irq));
    dtc_pins_model pins (.clk_i(clk_i), .t1_clk_o(p1c),
        .t1_dir_o(p1d), .t2_clk_o(p2c), .t2_dir_o(p2d));

    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Whole run is under a thousand cycles; this cuts a hang
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ====================
    // Classic single cycle; ack and data are looked at mid-cycle, where
    // they are settled, and the request is released at the next edge
    task automatic acc(input logic [13:0] i, input logic w,
                       input logic [15:0] v);
        @(posedge clk_i);
        {cyc, stb, we} <= {2'h3, w};
        adr <= {i, 2'h0};
        wdat <= {16'h0000, v};
        sel <= 4'h3;
        do @(negedge clk_i); while (ack !== 1'b1);
        d = rdat[15:0];
        @(posedge clk_i);
        {cyc, stb} <= 2'h0;
    endtask
    task automatic wr(input logic [13:0] i, input logic [15:0] v);
        acc(i, 1'b1, v);
    endtask
    task automatic rd(input logic [13:0] i);
        acc(i, 1'b0, 16'h0000);
    endtask
    // ====================
    // Scenarios
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) begin
            rd(regs[i]);
            `CHK("reset", 16'h0000, d)
        end
        rd(14'h0000);
        `CHK("unmapped", 16'h0000, d)
        wr(IDX_MASK, 16'h0002);
        wr(IDX_VALUE1, 16'hFFFD);
        wr(IDX_CTRL1, 16'h00C0);
        repeat (20) @(posedge clk_i);
        `CHK("irq masked", 1'b0, irq)
        wr(IDX_CTRL1, 16'h0000);
        rd(IDX_VALUE1);
        `CHK("wrap", 1'b1, d inside {[16'h0001:16'h0020]})
        wr(IDX_VALUE2, 16'h0002);
        wr(IDX_CTRL2, 16'h0080);
        repeat (12) @(posedge clk_i);
        `CHK("irq", 1'b1, irq)
        wr(IDX_CTRL2, 16'h0000);
        rd(IDX_PEND);
        `CHK("pending", 16'h0003, d)
        `CHK("irq clear", 1'b0, irq)
        rd(IDX_PEND);
        `CHK("pending clear", 16'h0000, d)
        wr(IDX_VALUE1, 16'h0100);
        wr(IDX_CTRL1, 16'h0083);
        repeat (160) @(posedge clk_i);
        wr(IDX_CTRL1, 16'h0000);
        rd(IDX_VALUE1);
        `CHK("prescale", 1'b1, d inside {[16'h00F5:16'h00F7]})
        wr(IDX_RELOAD, 16'h1234);
        wr(IDX_VALUE1, 16'hFFFE);
        wr(IDX_VALUE2, 16'h0000);
        wr(IDX_CTRL2, 16'h00E0);
        wr(IDX_CTRL1, 16'h00B0);
        pins.quad1(8);
        rd(IDX_VALUE1);
        `CHK("reload", 16'h1234, d)
        rd(IDX_RELOAD);
        `CHK("reload kept", 16'h1234, d)
        rd(IDX_VALUE2);
        `CHK("cascade", 16'h0001, d)
        wr(IDX_CTRL1, 16'h0000);
        wr(IDX_VALUE2, 16'h0000);
        pins.dir2(1'b1);
        wr(IDX_CTRL2, 16'h0098);
        pins.ext2(3, 4);
        rd(IDX_VALUE2);
        `CHK("external", 16'h0003, d)
        end_of_test();
    end
endmodule

`default_nettype wire
